/* hdl/abx_alu.sv */
`timescale 1ns/1ps

module abx_alu
  import abx_pkg::*;
(
  input  wire abx_instr_s ins_i,   // Decoded instruction
  input  wire logic [7:0] acc_i,   // Accumulator
  input  wire logic [7:0] opnd_i,  // File operand
  output abx_alu_s        res_o    // Result and flag updates
);

  logic [7:0] b_op;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] mask;

  always_comb begin
    b_op = (ins_i.op == op_add_immediate_to_acc || ins_i.op == op_and_immediate_with_acc)
           ? ins_i.lit : opnd_i;
    sum9 = {1'b0, acc_i} + {1'b0, b_op};
    nib5 = {1'b0, acc_i[3:0]} + {1'b0, b_op[3:0]};
    mask = 8'h01 << ins_i.bitpos;
    res_o = '0;
    case (ins_i.op)
      op_add_immediate_to_acc, op_add_acc_to_file: begin
        res_o.value             = sum9[7:0];
        res_o.carry             = sum9[8];
        res_o.nibble_carry_flag = nib5[4];
        res_o.zero              = (sum9[7:0] == 8'h00);
        res_o.wr_c              = 1'b1;
        res_o.wr_dc             = 1'b1;
        res_o.wr_z              = 1'b1;
      end
      op_and_immediate_with_acc, op_and_acc_with_file: begin
        res_o.value = acc_i & b_op;
        res_o.zero  = ((acc_i & b_op) == 8'h00);
        res_o.wr_z  = 1'b1;
      end
      op_file_bit_clear: begin
        res_o.value   = opnd_i & ~mask;
        res_o.to_file = 1'b1;
      end
      op_file_bit_set: begin
        res_o.value   = opnd_i | mask;
        res_o.to_file = 1'b1;
      end
      op_test_bit_skip_when_one: begin
        res_o.skip = opnd_i[ins_i.bitpos];
      end
      op_zero_file_register: begin
        res_o.value   = 8'h00;
        res_o.zero    = 1'b1;
        res_o.wr_z    = 1'b1;
        res_o.to_file = 1'b1;
      end
      default: begin
        res_o.value = 8'h00;
      end
    endcase
    case (ins_i.op)
      op_add_immediate_to_acc, op_and_immediate_with_acc: begin
        res_o.to_acc = 1'b1;
      end
      op_add_acc_to_file, op_and_acc_with_file: begin
        res_o.to_acc  = ~ins_i.dest;
        res_o.to_file = ins_i.dest;
      end
      default: begin
        res_o.to_acc = 1'b0;
      end
    endcase
  end

endmodule

/* hdl/abx_defines.svh */
`ifndef ABX_DEFINES_SVH
`define ABX_DEFINES_SVH

// ****************************************************************
// Register byte offsets on the Wishbone slave
// ****************************************************************
`define ABX_ADR_INSTR      12'h000
`define ABX_ADR_ACC        12'h004
`define ABX_ADR_FLAGS      12'h008
`define ABX_ADR_RETIRED    12'h00C
`define ABX_ADR_LAST       12'h010
`define ABX_FILE_SEL_HI    3'h1

// ****************************************************************
// Flags register bit positions
// ****************************************************************
`define ABX_FLAG_C         0
`define ABX_FLAG_DC        1
`define ABX_FLAG_Z         2
`define ABX_FLAG_SKIP      3
`define ABX_FLAG_PEND      4
`define ABX_FLAG_BADOP     5

// ****************************************************************
// Reset values
// ****************************************************************
`define ABX_ACC_RST        8'h00
`define ABX_LATCH_RST      8'h00
`define ABX_RETIRED_RST    16'h0000

// ****************************************************************
// Instruction word fields and opcode patterns
// ****************************************************************
`define ABX_F_DEST         7
`define ABX_F_FADDR_HI     6
`define ABX_F_BIT_HI       9
`define ABX_F_BIT_LO       7
`define ABX_OPC_ADD_ACC_TO_FILE_HI   6'h07
`define ABX_OPC_AND_ACC_WITH_FILE_HI   6'h05
`define ABX_OPC_ZERO_FILE_REGISTER_HI    7'h03
`define ABX_OPC_BCF_HI     4'h4
`define ABX_OPC_BSF_HI     4'h5
`define ABX_OPC_TEST_BIT_SKIP_WHEN_ONE_HI   4'h7
`define ABX_OPC_ADD_IMMEDIATE_TO_ACC_HI   5'h1F
`define ABX_OPC_AND_IMMEDIATE_WITH_ACC_HI   6'h39

// ****************************************************************
// Timing and map constants
// ****************************************************************
`define ABX_ICYC_LAST      2'h3
`define ABX_PORT_FADDR     7'h06

`endif

/* hdl/abx_exec_unit.sv */
`timescale 1ns/1ps
`include "abx_defines.svh"

module abx_exec_unit
  import abx_pkg::*;
(
  input  wire logic        clk_i,         // 10 MHz clock
  input  wire logic        rst_i,         // Synchronous reset, active high
  input  wire logic        wb_cyc_i,      // Wishbone cycle
  input  wire logic        wb_stb_i,      // Wishbone strobe
  input  wire logic        wb_we_i,       // Wishbone write enable
  input  wire logic [11:0] wb_adr_i,      // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,      // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,      // Wishbone write data
  output logic      [31:0] wb_dat_o,      // Wishbone read data
  output logic             wb_ack_o,      // Wishbone acknowledge
  input  wire logic [7:0]  port_pins_i,   // Levels on the port pins
  output logic      [7:0]  port_latch_o,  // Port output latch
  output logic             skip_o         // Next instruction will be dropped
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic abx_reg_e reg_decode(input logic [11:0] adr);
    abx_reg_e r;
    r = reg_none;
    if (adr[11:9] == `ABX_FILE_SEL_HI) begin
      r = reg_file;
    end else begin
      case (adr)
        `ABX_ADR_INSTR:   r = reg_instr;
        `ABX_ADR_ACC:     r = reg_acc;
        `ABX_ADR_FLAGS:   r = reg_flags;
        `ABX_ADR_RETIRED: r = reg_retired;
        `ABX_ADR_LAST:    r = reg_last;
        default:          r = reg_none;
      endcase
    end
    return r;
  endfunction

  function automatic abx_instr_s instr_decode(input logic [13:0] w);
    abx_instr_s d;
    d.dest   = w[`ABX_F_DEST];
    d.faddr  = w[`ABX_F_FADDR_HI:0];
    d.bitpos = w[`ABX_F_BIT_HI:`ABX_F_BIT_LO];
    d.lit    = w[7:0];
    if (w[13:9] == `ABX_OPC_ADD_IMMEDIATE_TO_ACC_HI) begin
      d.op = op_add_immediate_to_acc;
    end else if (w[13:8] == `ABX_OPC_AND_IMMEDIATE_WITH_ACC_HI) begin
      d.op = op_and_immediate_with_acc;
    end else if (w[13:8] == `ABX_OPC_ADD_ACC_TO_FILE_HI) begin
      d.op = op_add_acc_to_file;
    end else if (w[13:8] == `ABX_OPC_AND_ACC_WITH_FILE_HI) begin
      d.op = op_and_acc_with_file;
    end else if (w[13:7] == `ABX_OPC_ZERO_FILE_REGISTER_HI) begin
      d.op = op_zero_file_register;
    end else if (w[13:10] == `ABX_OPC_BCF_HI) begin
      d.op = op_file_bit_clear;
    end else if (w[13:10] == `ABX_OPC_BSF_HI) begin
      d.op = op_file_bit_set;
    end else if (w[13:10] == `ABX_OPC_TEST_BIT_SKIP_WHEN_ONE_HI) begin
      d.op = op_test_bit_skip_when_one;
    end else begin
      d.op = op_unsupported;
    end
    return d;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]   file_mem [0:127];
  logic [1:0]   div_reg;
  logic         icyc_en_reg;
  logic         slot_valid_reg;
  logic [13:0]  slot_word_reg;
  logic         skip_reg;
  logic [7:0]   acc_reg;
  logic         c_reg;
  logic         dc_reg;
  logic         z_reg;
  logic         badop_reg;
  logic [15:0]  retired_reg;
  logic [7:0]   last_reg;
  logic [7:0]   latch_reg;
  logic         ack_reg;
  logic [31:0]  dat_reg;

  abx_instr_s   ins;
  abx_alu_s     res;
  logic [7:0]   opnd;
  logic         exec_fire;
  logic         drop_fire;
  abx_reg_e     bus_sel;
  logic         bus_req;
  logic         bus_ok;
  logic         bus_go;
  logic         bus_wr;
  logic [31:0]  rd_val;
  logic [7:0]   bus_file_val;

  // ****************************************************************
  // Instruction cycle divider
  // ****************************************************************
  // One instruction cycle spans four clocks; execution keys off the pulse, the bus hold-off off div_reg
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg     <= 2'h0;
      icyc_en_reg <= 1'b0;
    end else begin
      div_reg     <= (div_reg == `ABX_ICYC_LAST) ? 2'h0 : div_reg + 2'h1;
      icyc_en_reg <= (div_reg == `ABX_ICYC_LAST);
    end
  end

  // ****************************************************************
  // Execution
  // ****************************************************************
  assign ins       = instr_decode(slot_word_reg);
  assign exec_fire = icyc_en_reg & slot_valid_reg & ~skip_reg;
  assign drop_fire = icyc_en_reg & slot_valid_reg & skip_reg;

  // Port operand is the pin level so read-modify-write sees real pins
  assign opnd = (ins.faddr == `ABX_PORT_FADDR) ? port_pins_i
                                               : file_mem[ins.faddr];

  abx_alu u_alu (
    .ins_i  (ins),
    .acc_i  (acc_reg),
    .opnd_i (opnd),
    .res_o  (res)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_valid_reg <= 1'b0;
      slot_word_reg  <= 14'h0000;
    end else if (bus_wr && bus_sel == reg_instr) begin
      slot_valid_reg <= 1'b1;
      slot_word_reg  <= wb_dat_i[13:0];
    end else if (exec_fire || drop_fire) begin
      slot_valid_reg <= 1'b0;
    end
  end

  // A taken skip stays armed until the next instruction arrives and is dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_reg <= 1'b0;
    end else if (drop_fire) begin
      skip_reg <= 1'b0;
    end else if (exec_fire && res.skip) begin
      skip_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_reg <= `ABX_ACC_RST;
    end else if (exec_fire && res.to_acc) begin
      acc_reg <= res.value;
    end else if (bus_wr && bus_sel == reg_acc) begin
      acc_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (exec_fire && res.to_file && ins.faddr != `ABX_PORT_FADDR) begin
      file_mem[ins.faddr] <= res.value;
    end else if (bus_wr && bus_sel == reg_file && wb_adr_i[8:2] != `ABX_PORT_FADDR) begin
      file_mem[wb_adr_i[8:2]] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_reg <= `ABX_LATCH_RST;
    end else if (exec_fire && res.to_file && ins.faddr == `ABX_PORT_FADDR) begin
      latch_reg <= res.value;
    end else if (bus_wr && bus_sel == reg_file && wb_adr_i[8:2] == `ABX_PORT_FADDR) begin
      latch_reg <= wb_dat_i[7:0];
    end
  end

  // Execution changes only the flags the instruction says; others hold; a flags write loads C, DC and Z
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_reg  <= 1'b0;
      dc_reg <= 1'b0;
      z_reg  <= 1'b0;
    end else if (exec_fire) begin
      if (res.wr_c) begin
        c_reg <= res.carry;
      end
      if (res.wr_dc) begin
        dc_reg <= res.nibble_carry_flag;
      end
      if (res.wr_z) begin
        z_reg <= res.zero;
      end
    end else if (bus_wr && bus_sel == reg_flags) begin
      c_reg  <= wb_dat_i[`ABX_FLAG_C];
      dc_reg <= wb_dat_i[`ABX_FLAG_DC];
      z_reg  <= wb_dat_i[`ABX_FLAG_Z];
    end
  end

  // Sticky unsupported-opcode flag; set wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      badop_reg <= 1'b0;
    end else if (exec_fire && ins.op == op_unsupported) begin
      badop_reg <= 1'b1;
    end else if (bus_wr && bus_sel == reg_flags && wb_dat_i[`ABX_FLAG_BADOP]) begin
      badop_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      retired_reg <= `ABX_RETIRED_RST;
      last_reg    <= 8'h00;
    end else if (exec_fire) begin
      retired_reg <= retired_reg + 16'h0001;
      last_reg    <= res.value;
    end
  end

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  // Writes land at the edge where the master sees ack; taking is held off
  // when that edge is an instruction tick so bus and core never collide
  assign bus_sel = reg_decode(wb_adr_i);
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_ok  = ~wb_we_i | ((div_reg != `ABX_ICYC_LAST)
                               & ~(bus_sel == reg_instr && slot_valid_reg));
  assign bus_go  = bus_req & bus_ok;
  assign bus_wr  = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];

  assign bus_file_val = (wb_adr_i[8:2] == `ABX_PORT_FADDR) ? port_pins_i
                                                           : file_mem[wb_adr_i[8:2]];

  always_comb begin
    rd_val = 32'h0000_0000;
    case (bus_sel)
      reg_instr: begin
        rd_val[13:0] = slot_word_reg;
      end
      reg_acc: begin
        rd_val[7:0] = acc_reg;
      end
      reg_flags: begin
        rd_val[`ABX_FLAG_C]     = c_reg;
        rd_val[`ABX_FLAG_DC]    = dc_reg;
        rd_val[`ABX_FLAG_Z]     = z_reg;
        rd_val[`ABX_FLAG_SKIP]  = skip_reg;
        rd_val[`ABX_FLAG_PEND]  = slot_valid_reg;
        rd_val[`ABX_FLAG_BADOP] = badop_reg;
      end
      reg_retired: begin
        rd_val[15:0] = retired_reg;
      end
      reg_last: begin
        rd_val[7:0] = last_reg;
      end
      reg_file: begin
        rd_val[7:0] = bus_file_val;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_go;
      dat_reg <= (bus_go && !wb_we_i) ? rd_val : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = dat_reg;
  assign port_latch_o = latch_reg;
  assign skip_o       = skip_reg;

endmodule

/* hdl/abx_pkg.sv */
package abx_pkg;

  typedef enum logic [3:0] {
    op_nop,
    op_add_immediate_to_acc,
    op_and_immediate_with_acc,
    op_add_acc_to_file,
    op_and_acc_with_file,
    op_file_bit_clear,
    op_file_bit_set,
    op_test_bit_skip_when_one,
    op_zero_file_register,
    op_unsupported
  } abx_op_e;

  typedef enum logic [2:0] {
    reg_instr,
    reg_acc,
    reg_flags,
    reg_retired,
    reg_last,
    reg_file,
    reg_none
  } abx_reg_e;

  typedef struct packed {
    abx_op_e      op;
    logic         dest;
    logic [6:0]   faddr;
    logic [2:0]   bitpos;
    logic [7:0]   lit;
  } abx_instr_s;

  typedef struct packed {
    logic [7:0]   value;
    logic         carry;
    logic         nibble_carry_flag;
    logic         zero;
    logic         wr_c;
    logic         wr_dc;
    logic         wr_z;
    logic         to_acc;
    logic         to_file;
    logic         skip;
  } abx_alu_s;

endpackage

/* verification/abx_exec_unit_chk.sv */
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module abx_exec_unit_chk (
  input wire logic        clk_i,         // Clock
  input wire logic        rst_i,         // Reset
  input wire logic        wb_cyc_i,      // Cycle
  input wire logic        wb_stb_i,      // Strobe
  input wire logic        wb_we_i,       // Write enable
  input wire logic [11:0] wb_adr_i,      // Address
  input wire logic [3:0]  wb_sel_i,      // Selects
  input wire logic [31:0] wb_dat_i,      // Write data
  input wire logic [31:0] wb_dat_o,      // Read data
  input wire logic        wb_ack_o,      // Acknowledge
  input wire logic [7:0]  port_pins_i,   // Pin levels
  input wire logic [7:0]  port_latch_o,  // Port latch
  input wire logic        skip_o         // Skip pending
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Saturates so a stale write never excuses a late change
  logic [3:0] since_ins;
  always_ff @(posedge clk_i) begin
    if (rst_i) since_ins <= 4'hF;
    else if (wb_ack_o && wb_we_i && wb_adr_i == 12'h000) since_ins <= 4'h0;
    else if (since_ins != 4'hF) since_ins <= since_ins + 4'h1;
  end

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_idle_dat_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_read_one_clk: assert property ((wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> wb_ack_o)
    else $error("read not answered in one clock");
  a_write_bounded: assert property (
    $rose(wb_cyc_i && wb_stb_i && wb_we_i) |-> ##[1:12] wb_ack_o)
    else $error("write not answered in time");
  a_skip_rise_cause: assert property ($rose(skip_o) |-> since_ins <= 4'h8)
    else $error("skip raised without instruction");
  a_skip_fall_cause: assert property ($fell(skip_o) |-> since_ins <= 4'h8)
    else $error("skip dropped without next instruction");
  a_skip_holds: assert property ((skip_o && since_ins == 4'hF) |=> skip_o)
    else $error("skip lost while idle");
  a_latch_cause: assert property (
    $changed(port_latch_o) |-> $past(wb_ack_o && wb_we_i) || since_ins <= 4'h8)
    else $error("port latch changed without cause");
endmodule

bind abx_exec_unit abx_exec_unit_chk abx_exec_unit_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_pins_i(port_pins_i),
  .port_latch_o(port_latch_o), .skip_o(skip_o));

/* verification/abx_exec_unit_tb_top.sv */
`timescale 1ns/1ps
module abx_exec_unit_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [7:0]  pins = 8'h00;
  logic [31:0] dat_r;
  logic        ack;
  logic [7:0]  latch;
  logic        skip;
  logic [31:0] q;
  int          bad_count, check_count, acc, c, dc, z, skp, latch_m, i, fa, p;
  int          fr[128];

  always #50 clk_i = ~clk_i;

  abx_exec_unit abx_exec_unit_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .port_pins_i(pins), .port_latch_o(latch), .skip_o(skip));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dat_r;
    if (n >= 40) bad_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // ****************************************
  // Issue one instruction, update model, compare
  // ****************************************
  task automatic exec(input int k, input int f, input int b, input int d, input int lit);
    logic [13:0] w;
    int          o, s, r;
    o = (k < 2) ? lit : ((f == 6) ? int'(pins) : fr[f]);
    case (k)
      0: w = {6'h3E, lit[7:0]};
      1: w = {6'h39, lit[7:0]};
      2: w = {6'h07, d[0], f[6:0]};
      3: w = {6'h05, d[0], f[6:0]};
      4: w = {4'h4, b[2:0], f[6:0]};
      5: w = {4'h5, b[2:0], f[6:0]};
      6: w = {4'h7, b[2:0], f[6:0]};
      default: w = {7'h03, f[6:0]};
    endcase
    wb(1'b1, 12'h000, {18'h0, w});
    if (skp) skp = 0;
    else begin
      case (k)
        0, 2: begin
          s = acc + o;
          dc = ((acc & 15) + (o & 15)) > 15;
          c = s > 255;
          r = s & 255;
          z = (r == 0);
        end
        1, 3: begin
          r = acc & o;
          z = (r == 0);
        end
        4: r = o & ~(1 << b);
        5: r = o | (1 << b);
        6: begin
          r = o;
          skp = (o >> b) & 1;
        end
        default: begin
          r = 0;
          z = 1;
        end
      endcase
      if (k < 2 || (k < 4 && d == 0)) acc = r;
      else if (k != 6 && f == 6) latch_m = r;
      else if (k != 6) fr[f] = r;
    end
    // Poll pending; the final read also gives the flags
    repeat (20) begin
      wb(1'b0, 12'h008, 32'h0);
      if (q[4] === 1'b0) break;
    end
    chk("flags", q, skp * 8 + z * 4 + dc * 2 + c);
    chk("skip_o", {31'h0, skip}, skp);
    wb(1'b0, 12'h004, 32'h0);
    chk("acc", q, acc);
    if (f != 6) begin
      wb(1'b0, 12'h200 + 12'(f * 4), 32'h0);
      chk("file", q, fr[f]);
    end
    chk("latch", {24'h0, latch}, latch_m);
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #3000000;
    bad_count++;
    summarize;
  end

  initial begin
    void'($urandom(75210));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 12'h004, 32'h0);
    chk("acc_rst", q, 32'h0);
    wb(1'b0, 12'h008, 32'h0);
    chk("flags_rst", q, 32'h0);
    wb(1'b0, 12'h100, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b1, 12'h218, 32'h0);
    for (i = 0; i < 8; i++) begin
      fa = (i == 7) ? 127 : 32 + i;
      fr[fa] = $urandom % 256;
      wb(1'b1, 12'h200 + 12'(fa * 4), fr[fa]);
    end
    // Every kind once, then random mixes with boundary address
    for (i = 0; i < 80; i++) begin
      fa = $urandom % 8;
      fa = (fa == 7) ? 127 : 32 + fa;
      exec((i < 8) ? i : $urandom % 8, fa, $urandom % 8, $urandom % 2, $urandom % 256);
    end
    // Port read-modify-write sees pins, not latch
    for (i = 0; i < 8; i++) begin
      p = $urandom % 256;
      pins <= p[7:0];
      repeat (3) @(posedge clk_i);
      exec(4 + i % 2, 6, $urandom % 8, 1, 0);
    end
    summarize;
  end
endmodule
